// ### logic/saif_pkg.sv
// Constants for the serial audio input format block.
// Assumes an APB master with 16-bit byte addresses and 32-bit data.
package saif_pkg;
   // Printed offsets are word indices; byte address is four times the index
   localparam int CFG_IDX = 32'h0000_081F;
   localparam int STS_IDX = 32'h0000_0820;
   localparam logic [15:0] CFG_ADDR = 16'(CFG_IDX * 4);
   localparam logic [15:0] STS_ADDR = 16'(STS_IDX * 4);
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_MASK = 8'h1F;
   localparam int POL_BIT = 4;
   localparam int EDGE_BIT = 3;
   localparam int LOCK_BIT = 5;
   localparam logic [2:0] MODE_I2S = 3'h0;
   localparam logic [2:0] MODE_LJ = 3'h1;
   localparam logic [2:0] MODE_TDM = 3'h2;
   localparam logic [2:0] MODE_RJ24 = 3'h3;
   localparam logic [2:0] MODE_RJ20 = 3'h4;
   localparam int SAMPLE_BITS = 24;
   localparam int RJ20_PAD = 4;
   localparam int TDM_SLOTS = 8;
   localparam int SLOT_BITS = 32;
   localparam logic [7:0] MSB_DELAY = 8'h01;
   localparam logic [7:0] SLOT_LAST = 8'(SLOT_BITS - 1);
   localparam logic [3:0] SLOT_END = 4'(TDM_SLOTS);
endpackage

// ### logic/saif_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is independent; no bus coherence is implied.
`timescale 1ns/10ps
module saif_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Levels
   input wire logic [W-1:0] in_bits,
   output logic [W-1:0] out_bits
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] out_next;

   always_comb begin
      meta_next = in_bits;
      out_next = meta_reg;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_reg <= '0;
         out_bits <= '0;
      end else begin
         meta_reg <= meta_next;
         out_bits <= out_next;
      end
   end
endmodule // saif_sync

// ### logic/saif_rx.sv
// Serial audio input port with its format control register on APB.
// Assumes bit clock, word clock and data come from an external source.
// Function
// - Control resets to 0x00; bit 4 polarity, 3 edge, 2..0 format.
// - Standard stereo, polarity clear: left while word clock low, right while high.
// - TDM frame starts after falling word clock, rising if polarity set.
// - TDM word clock may be one pulse per frame; only the start edge counts.
// - Edge bit 0: data changes falling, captured rising; 1: the reverse.
// - Justified formats put left in the high word clock phase by default.
// - TDM stream arrives on the first serial input only.
// - TDM slot MSB comes one bit clock after the slot begins.
// - Eight TDM channels; 0..3 first half of frame, 4..7 second.
// - Format codes: 000 std, 001 left, 010 TDM, 011 right 24, 100 right 20.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module saif_rx
   import saif_pkg::*;
#(
   parameter int NUM_IN = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic [15:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Audio link
   input wire logic bit_clock,
   input wire logic word_clock,
   input wire logic [NUM_IN-1:0] serial_audio_inputs,
   // Decoded samples
   output logic sample_valid,
   output logic [2:0] sample_channel,
   output logic [NUM_IN-1:0] sample_lines,
   output logic [NUM_IN*SAMPLE_BITS-1:0] sample_data
);
   typedef enum logic {SAIF_HUNT, SAIF_RUN} saif_state_e;

   function automatic logic saif_left_high(input logic [7:0] c);
      logic just;
      just = (c[2:0] == MODE_LJ) || (c[2:0] == MODE_RJ24) ||
             (c[2:0] == MODE_RJ20);
      return just ^ c[POL_BIT];
   endfunction

   function automatic logic saif_is_start(input logic [7:0] c,
                                          input logic lv);
      if (c[2:0] == MODE_TDM)
         return lv == c[POL_BIT];
      return lv == saif_left_high(c);
   endfunction

   function automatic logic [SAMPLE_BITS-1:0] saif_extract(
      input logic [2:0] m, input logic [SAMPLE_BITS-1:0] s);
      if (m == MODE_RJ20)
         return {s[SAMPLE_BITS-RJ20_PAD-1:0], {RJ20_PAD{1'b0}}};
      return s;
   endfunction

   logic [NUM_IN+1:0] sync_out;
   logic bclk_s;
   logic lr_s;
   logic [NUM_IN-1:0] din_s;

   saif_sync #(.W(NUM_IN + 2)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_bits({word_clock, bit_clock, serial_audio_inputs}),
      .out_bits(sync_out)
   );
   assign {lr_s, bclk_s, din_s} = sync_out;

   // Bus group
   logic [7:0] cfg_reg, cfg_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next;
   logic acc, hit_cfg, hit_sts;

   // Receiver group
   saif_state_e state_reg, state_next;
   logic [7:0] act_reg, act_next;
   logic bclk_d_reg, bclk_d_next;
   logic lr_d_reg, lr_d_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [3:0] slot_reg, slot_next;
   logic [SAMPLE_BITS-1:0] sh_reg [NUM_IN];
   logic [SAMPLE_BITS-1:0] sh_next [NUM_IN];
   logic valid_next;
   logic [2:0] chan_next;
   logic [NUM_IN-1:0] lines_next;
   logic [NUM_IN*SAMPLE_BITS-1:0] data_next;
   logic cap, lr_chg, frame_edge, tdm_old, tdm_new, take;
   logic [7:0] use_cfg, delay;

   always_comb begin
      acc = psel && penable;
      hit_cfg = paddr == CFG_ADDR;
      hit_sts = paddr == STS_ADDR;
      cfg_next = cfg_reg;
      prdata_next = prdata;
      pslverr_next = 1'b0;
      pready_next = acc && !pready;
      if (acc && !pready) begin
         prdata_next = 32'h0;
         if (hit_cfg)
            prdata_next[7:0] = cfg_reg;
         else if (hit_sts)
            prdata_next[LOCK_BIT:0] = {state_reg == SAIF_RUN, act_reg[4:0]};
         // Status is read-only, so a write to it is refused
         pslverr_next = !(hit_cfg || (hit_sts && !pwrite));
      end
      // One write carries polarity, edge and format at once
      if (acc && pready && pwrite && hit_cfg)
         cfg_next = pwdata[7:0] & CFG_MASK;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_reg <= CFG_RESET;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
      end
   end

   always_comb begin
      bclk_d_next = bclk_s;
      // Edge bit 0 captures on rising, 1 on falling
      cap = act_reg[EDGE_BIT] ? (bclk_d_reg && !bclk_s) :
                                (!bclk_d_reg && bclk_s);
      lr_chg = cap && (lr_s != lr_d_reg);
      use_cfg = (state_reg == SAIF_RUN) ? act_reg : cfg_reg;
      frame_edge = lr_chg && saif_is_start(use_cfg, lr_s);
      lr_d_next = cap ? lr_s : lr_d_reg;
      state_next = state_reg;
      act_next = act_reg;
      if (frame_edge) begin
         act_next = cfg_reg;
         state_next = SAIF_RUN;
      end
      tdm_old = act_reg[2:0] == MODE_TDM;
      tdm_new = act_next[2:0] == MODE_TDM;
      delay = (act_next[2:0] == MODE_LJ) ? 8'h00 : MSB_DELAY;
      cnt_next = cnt_reg;
      slot_next = slot_reg;
      valid_next = 1'b0;
      chan_next = sample_channel;
      lines_next = sample_lines;
      data_next = sample_data;
      for (int i = 0; i < NUM_IN; i++)
         sh_next[i] = sh_reg[i];
      if (cap && (state_reg == SAIF_RUN || frame_edge)) begin
         if (!tdm_old && lr_chg && state_reg == SAIF_RUN) begin
            // Half ended: every line delivers the finished word
            valid_next = 1'b1;
            chan_next = (lr_d_reg == saif_left_high(act_reg)) ?
                        3'h0 : 3'h1;
            lines_next = '1;
            for (int i = 0; i < NUM_IN; i++)
               data_next[i*SAMPLE_BITS +: SAMPLE_BITS] =
                  saif_extract(act_reg[2:0], sh_reg[i]);
         end else if (tdm_old && state_reg == SAIF_RUN &&
                      slot_reg < SLOT_END &&
                      (cnt_reg == SLOT_LAST || frame_edge)) begin
            valid_next = 1'b1;
            chan_next = slot_reg[2:0];
            lines_next = '0;
            lines_next[0] = 1'b1;
            data_next = '0;
            data_next[SAMPLE_BITS-1:0] = sh_reg[0];
         end
         if (frame_edge || (!tdm_old && lr_chg)) begin
            cnt_next = 8'h00;
            slot_next = 4'h0;
         end else if (tdm_old && cnt_reg == SLOT_LAST) begin
            cnt_next = 8'h00;
            // Past the eighth slot the port idles until the next start
            if (slot_reg < SLOT_END)
               slot_next = slot_reg + 4'h1;
         end else if (cnt_reg != 8'hFF) begin
            cnt_next = cnt_reg + 8'h01;
         end
         // Justified-right words are the last bits before the change
         take = (act_next[2:0] == MODE_RJ24) ||
                (act_next[2:0] == MODE_RJ20) ||
                (cnt_next >= delay &&
                 cnt_next < delay + 8'(SAMPLE_BITS));
         if (tdm_new && slot_next >= SLOT_END)
            take = 1'b0;
         for (int i = 0; i < NUM_IN; i++)
            if (take && (!tdm_new || i == 0))
               sh_next[i] = {sh_reg[i][SAMPLE_BITS-2:0], din_s[i]};
      end else begin
         take = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= SAIF_HUNT;
         act_reg <= CFG_RESET;
         bclk_d_reg <= 1'b0;
         lr_d_reg <= 1'b0;
         cnt_reg <= 8'h00;
         slot_reg <= 4'h0;
         for (int i = 0; i < NUM_IN; i++)
            sh_reg[i] <= '0;
         sample_valid <= 1'b0;
         sample_channel <= 3'h0;
         sample_lines <= '0;
         sample_data <= '0;
      end else begin
         state_reg <= state_next;
         act_reg <= act_next;
         bclk_d_reg <= bclk_d_next;
         lr_d_reg <= lr_d_next;
         cnt_reg <= cnt_next;
         slot_reg <= slot_next;
         for (int i = 0; i < NUM_IN; i++)
            sh_reg[i] <= sh_next[i];
         sample_valid <= valid_next;
         sample_channel <= chan_next;
         sample_lines <= lines_next;
         sample_data <= data_next;
      end
   end

   default clocking saif_cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_wr_cfg;
      psel && penable && pready && pwrite && hit_cfg;
   endsequence
   sequence s_tdm_start;
      frame_edge && use_cfg[2:0] == MODE_TDM;
   endsequence
   sequence s_pulse_end;
      lr_chg && !frame_edge && tdm_old && state_reg == SAIF_RUN &&
      cnt_reg != SLOT_LAST;
   endsequence

   a_reset_zero: assert property (disable iff (1'b0)
      sys_rst |=> cfg_reg == CFG_RESET && act_reg == CFG_RESET)
      else $error("control register not zero after reset");
   a_cfg_write: assert property (s_wr_cfg |=>
      cfg_reg == ($past(pwdata[7:0]) & CFG_MASK) && cfg_reg[7:5] == 3'h0)
      else $error("control write not stored");
   a_capture_edge: assert property (sh_reg[0] != $past(sh_reg[0]) |->
      $past(bclk_s) == !$past(act_reg[EDGE_BIT]) &&
      $past(bclk_s) != $past(bclk_d_reg))
      else $error("data taken on wrong bit clock edge");
   a_tdm_start: assert property (s_tdm_start |=>
      slot_reg == 4'h0 && cnt_reg == 8'h00 &&
      lr_d_reg == $past(use_cfg[POL_BIT]))
      else $error("TDM frame did not start on polarity edge");
   a_pulse_ignore: assert property (s_pulse_end |=>
      $stable(slot_reg) && $stable(act_reg))
      else $error("trailing pulse edge restarted the frame");
   a_stereo_chan: assert property (
      sample_valid && sample_lines == '1 |-> sample_channel ==
      (($past(lr_d_reg) == saif_left_high($past(act_reg))) ? 3'h0 : 3'h1))
      else $error("stereo channel phase wrong");
   a_tdm_line0: assert property (
      sample_valid && sample_channel > 3'h1 |-> sample_lines == NUM_IN'(1))
      else $error("TDM sample not on first input");
   a_msb_delay: assert property (cap && !lr_chg && tdm_old &&
      state_reg == SAIF_RUN && cnt_reg == SLOT_LAST |=> $stable(sh_reg[0]))
      else $error("slot bit zero taken as data");
   a_cfg_boundary: assert property ($changed(act_reg) |->
      $past(frame_edge) && act_reg == $past(cfg_reg))
      else $error("settings changed inside a frame");
endmodule // saif_rx

// ### tb/saif_source.sv
// Behavioural audio source driving the serial audio input link.
// Assumes the bench sets the format inputs before raising go.
`timescale 1ns/10ps
module saif_source
   import saif_pkg::*;
(
   // Bench control
   input wire logic go,
   input wire logic [2:0] mode,
   input wire logic pol,
   input wire logic edge_sel,
   input wire logic pulse,
   output logic busy,
   output logic framing,
   // Link
   output logic bit_clock,
   output logic word_clock,
   output logic [3:0] serial_audio_inputs
);
   logic left, tdm, wcl;
   logic [3:0] v;
   int nb;
   function automatic logic [23:0] wd(input int ch, input int ln);
      return {4'hA, 4'(ln), 4'h3, 4'(ch), 8'hC5};
   endfunction
   function automatic logic bitv(input logic [2:0] m, input int k,
                                 input logic [23:0] w);
      case (m)
         MODE_LJ: return (k <= 23) ? w[23-k] : 1'b0;
         MODE_RJ24: return (k >= 8) ? w[31-k] : 1'b0;
         MODE_RJ20: return (k >= 12) ? w[35-k] : 1'b0;
         default: return (k >= 1 && k <= 24) ? w[24-k] : 1'b0;
      endcase
   endfunction
   // Data changes on the edge opposite to capture
   task send_bit(input logic w, input logic [3:0] d);
      bit_clock = edge_sel;
      word_clock = w;
      serial_audio_inputs = d;
      #62.5;
      bit_clock = ~edge_sel;
      #62.5;
   endtask
   initial begin
      busy = 1'b0;
      framing = 1'b0;
      bit_clock = 1'b0;
      word_clock = 1'b1;
      serial_audio_inputs = 4'h0;
   end
   // Bit clock stands still between bursts
   always begin
      wait (go === 1'b1);
      busy = 1'b1;
      tdm = (mode == MODE_TDM);
      left = (mode == MODE_I2S || tdm) ? pol : ~pol;
      nb = tdm ? 256 : 64;
      send_bit(~left, 4'h0);
      send_bit(~left, 4'h0);
      for (int f = 0; f < 2; f++) begin
         for (int b = 0; b < nb; b++) begin
            // The first start edge may close a stray word of the old
            // settings, so the checked window opens one bit later
            if (f == 0 && b == 1) framing = 1'b1;
            if (pulse) wcl = (b == 0) ? left : ~left;
            else wcl = (b < nb / 2) ? left : ~left;
            for (int l = 0; l < 4; l++) begin
               if (tdm && l != 0) v[l] = 1'(b);
               else v[l] = bitv(mode, b % 32, wd(b / 32, l));
            end
            send_bit(wcl, v);
         end
      end
      // Tail bit closes the last TDM slot without a new start
      if (tdm) send_bit(~left, ~v);
      bit_clock = 1'b0;
      serial_audio_inputs = ~v;
      #100;
      framing = 1'b0;
      busy = 1'b0;
      wait (go !== 1'b1);
   end
endmodule // saif_source

// ### tb/saif_rx_tb.sv
// Testbench for the serial audio input format block.
// Assumes the source model drives the link; APB is driven here.
`timescale 1ns/10ps
module saif_rx_tb import saif_pkg::*;;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] paddr = 16'h0000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, sample_valid, bit_clock, word_clock;
   logic [2:0] sample_channel;
   logic [3:0] sample_lines, sdi;
   logic [95:0] sample_data;
   logic go = 1'b0, pol = 1'b0, edge_sel = 1'b0, pulse = 1'b0;
   logic busy, framing;
   logic [2:0] mode = 3'h0;
   logic [4:0] prev;
   int n_mismatch = 0, tests_run = 0, n_samp = 0;
   // {pulse, polarity, edge, format}
   logic [5:0] cfgs [9] = '{6'h00, 6'h01, 6'h0B, 6'h14, 6'h18, 6'h11,
                            6'h02, 6'h32, 6'h0A};
   always #5 clk = ~clk;
   saif_rx #(.NUM_IN(4)) u_dut (.clk(clk), .sys_rst(sys_rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bit_clock(bit_clock), .word_clock(word_clock),
      .serial_audio_inputs(sdi), .sample_valid(sample_valid),
      .sample_channel(sample_channel), .sample_lines(sample_lines),
      .sample_data(sample_data));
   saif_source u_src (.go(go), .mode(mode), .pol(pol),
      .edge_sel(edge_sel), .pulse(pulse), .busy(busy),
      .framing(framing), .bit_clock(bit_clock), .word_clock(word_clock),
      .serial_audio_inputs(sdi));
   function automatic logic [23:0] wd(input int ch, input int ln);
      return {4'hA, 4'(ln), 4'h3, 4'(ch), 8'hC5};
   endfunction
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [95:0] g, input logic [95:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task apb(input logic wr, input logic [15:0] a, input logic [31:0] w);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= w;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         tally_and_finish;
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task burst;
      int n;
      go <= 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (n >= 100) begin
         n_mismatch++;
         tally_and_finish;
      end
      go <= 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20000) begin
         n_mismatch++;
         tally_and_finish;
      end
   endtask
   // Each word is checked in arrival order; stray words outside
   // the source's frames come from reconfiguration and are ignored
   task check_sample;
      logic [95:0] e;
      logic [23:0] w;
      int ch;
      ch = (mode == MODE_TDM) ? n_samp % 8 : n_samp % 2;
      for (int l = 0; l < 4; l++) begin
         w = wd(ch, l);
         if (mode == MODE_TDM && l != 0) e[l*24+:24] = 24'h0;
         else if (mode == MODE_RJ20) e[l*24+:24] = {w[23:4], 4'h0};
         else e[l*24+:24] = w;
      end
      chk(96'(sample_channel), 96'(ch));
      chk(96'(sample_lines), (mode == MODE_TDM) ? 96'h1 : 96'hF);
      chk(sample_data, e);
      n_samp++;
   endtask
   always @(posedge clk) begin
      if (framing === 1'b1 && sample_valid === 1'b1) check_sample;
   end
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, CFG_ADDR, 32'h0);
      chk(96'(rd), 96'(CFG_RESET));
      apb(1'b1, CFG_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, CFG_ADDR, 32'h0);
      chk(96'(rd), 96'(CFG_MASK));
      apb(1'b0, 16'h0000, 32'h0);
      chk(96'({er, rd}), 96'h1_0000_0000);
      apb(1'b1, STS_ADDR, 32'h0);
      chk(96'(er), 96'h1);
      prev = 5'h00;
      for (int i = 0; i < 9; i++) begin
         {pulse, pol, edge_sel, mode} <= cfgs[i];
         apb(1'b1, CFG_ADDR, 32'(cfgs[i][4:0]));
         apb(1'b0, STS_ADDR, 32'h0);
         chk(96'(rd[5:0]), 96'({i > 0, prev}));
         n_samp = 0;
         burst;
         chk(96'(n_samp), (mode == MODE_TDM) ? 96'h10 : 96'h3);
         apb(1'b0, STS_ADDR, 32'h0);
         chk(96'(rd[5:0]), 96'({1'b1, cfgs[i][4:0]}));
         prev = cfgs[i][4:0];
      end
      tally_and_finish;
   end
endmodule // saif_rx_tb
